/* File: rtl/ivs_pkg.sv */
// Constants, register map and types shared by the vector readback block
package ivs_pkg;
  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Source numbering
  localparam int NUM_SRC = 32;
  localparam int SRC_W = 5;
  localparam int PRIO_W = 3;
  localparam logic [SRC_W-1:0] FAST_SRC = 5'h00;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_PRIO_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_PRIO_LAST = 12'h07C;
  localparam logic [ADDR_W-1:0] OFF_HANDLER_BASE = 12'h080;
  localparam logic [ADDR_W-1:0] OFF_HANDLER_LAST = 12'h0FC;
  localparam logic [ADDR_W-1:0] OFF_NORMAL_VEC = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_FAST_VEC = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_CUR_SRC = 12'h108;
  localparam logic [ADDR_W-1:0] OFF_PENDING = 12'h10C;
  localparam logic [ADDR_W-1:0] OFF_ENABLED = 12'h110;
  localparam logic [ADDR_W-1:0] OFF_CORE_LINES = 12'h114;
  localparam logic [ADDR_W-1:0] OFF_PROTECT = 12'h138;
  // Word index field inside an offset
  localparam int IDX_LSB = 2;
  // Source bit layout of pending and enabled registers
  localparam logic [DATA_W-1:0] INT_SRC_MASK = 32'h000001FF;
  localparam int EXT_LSB = 16;
  localparam int EXT_CNT = 3;
  localparam logic [DATA_W-1:0] SRC_MASK = 32'h000701FF;
  // Core line status bits
  localparam int CORE_FAST_BIT = 0;
  localparam int CORE_NORMAL_BIT = 1;
  // Protect control bit
  localparam int PROTECT_BIT = 0;
  // Reset values
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
  localparam logic [SRC_W-1:0] ZERO_SRC = 5'h00;
  localparam logic [PRIO_W-1:0] ZERO_PRIO = 3'h0;

  // Register selected by an address
  typedef enum logic [3:0] {
    REG_PRIO = 4'h0,
    REG_HANDLER = 4'h1,
    REG_NORMAL_VEC = 4'h2,
    REG_FAST_VEC = 4'h3,
    REG_CUR_SRC = 4'h4,
    REG_PENDING = 4'h5,
    REG_ENABLED = 4'h6,
    REG_CORE_LINES = 4'h7,
    REG_PROTECT = 4'h8,
    REG_NONE = 4'hF
  } ivs_reg_e;

  // Bus transfer phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_DONE = 2'b10
  } ivs_phase_e;
endpackage

/* File: rtl/ivs_mem_if.sv */
// Interface between the register logic and the handler address memory
interface ivs_mem_if;
  import ivs_pkg::*;
  logic wr_en; // Write strobe, one cycle
  logic [SRC_W-1:0] wr_idx; // Word written
  logic [DATA_W-1:0] wr_data; // Data written
  logic [SRC_W-1:0] rd_idx; // Word read, registered next edge
  logic [DATA_W-1:0] rd_data; // Registered read data
  logic [DATA_W-1:0] fast_word; // Word of the fast source, always visible

  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx,
    input rd_data, input fast_word);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx,
    output rd_data, output fast_word);
endinterface

/* File: rtl/ivs_handler_mem.sv */
// Handler address memory: one word per source, registered read port
module ivs_handler_mem (
  input wire logic i_clock,
  input wire logic i_nrst,
  ivs_mem_if.mem mem_port
);
  import ivs_pkg::*;

  logic [DATA_W-1:0] words_q [NUM_SRC]; // Stored handler addresses

  ////////////////////////////////////////////////////////////////////////////
  // Storage: cleared at reset so every handler reads zero
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        words_q[i] <= ZERO_WORD; // R15
      end
    end else if (mem_port.wr_en) begin
      words_q[mem_port.wr_idx] <= mem_port.wr_data; // R1
    end
  end

  // Read port: data come out of a register one edge after the index
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      mem_port.rd_data <= ZERO_WORD;
    end else begin
      mem_port.rd_data <= words_q[mem_port.rd_idx];
    end
  end

  // Fast source word, used by checks only
  assign mem_port.fast_word = words_q[FAST_SRC];
endmodule

/* File: rtl/ivs_prio_select.sv */
// Picks the enabled pending normal source of highest priority
module ivs_prio_select
  import ivs_pkg::*;
(
  input wire logic [DATA_W-1:0] i_pending,
  input wire logic [DATA_W-1:0] i_enabled,
  input wire logic [NUM_SRC*PRIO_W-1:0] i_prio,
  output logic o_valid,
  output logic [SRC_W-1:0] o_index,
  output logic [PRIO_W-1:0] o_prio
);
  ////////////////////////////////////////////////////////////////////////////
  // Scan sources 1 upward; a tie keeps the lower number
  always_comb begin
    o_valid = 1'b0;
    o_index = ZERO_SRC;
    o_prio = ZERO_PRIO;
    for (int i = 1; i < NUM_SRC; i++) begin
      // Only strictly higher priority displaces an earlier pick
      if (i_pending[i] && i_enabled[i] &&
          (!o_valid || i_prio[i*PRIO_W +: PRIO_W] > o_prio)) begin
        o_valid = 1'b1; // R12
        o_index = SRC_W'(i);
        o_prio = i_prio[i*PRIO_W +: PRIO_W];
      end
    end
  end
endmodule

/* File: rtl/ivs_vector_regs.sv */
// Vector readback, status and core line block with its register bus slave
//
// Summary of operation
// (R1) Read/write handler address word per source
// (R2) Normal vector read returns eligible source handler
// (R3) Normal vector indexes handlers 1..31 by source
// (R4) No eligible source: normal vector reads zero
// (R5) Fast vector read returns handler word 0
// (R6) Status register low field: current source number
// (R7) Pending bits: internal 0..8, external 16..18
// (R8) Enabled bits share pending bit positions
// (R9) Core status bit 0: fast line active
// (R10) Core status bit 1: normal line active
// (R11) Protect mode: only vector write commits context
// (R12) Priority 0..7, highest enabled pending selected
// (R13) External pending follows lines, others cleared
// (R14) Writes to read-only registers change nothing
// (R15) Registers read zero after reset, except the external pending bits, which follow the pins
module ivs_vector_regs (
  input wire logic i_clock,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ivs_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [ivs_pkg::DATA_W-1:0] i_pwdata,
  output logic [ivs_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pending and enable state from the rest of the controller
  input wire logic [ivs_pkg::DATA_W-1:0] i_pending,
  input wire logic [ivs_pkg::DATA_W-1:0] i_enabled,
  // External request pins, asynchronous
  input wire logic [ivs_pkg::EXT_CNT-1:0] i_external_request,
  // End of service pulse from the end-of-interrupt logic
  input wire logic i_end_of_service,
  // Lines toward the core and current context
  output logic o_fast_request_line_n,
  output logic o_normal_request_line_n,
  output logic [ivs_pkg::SRC_W-1:0] o_current_source,
  output logic o_in_service
);
  import ivs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by setup and completion phases
  function automatic ivs_reg_e decode(input logic [ADDR_W-1:0] addr);
    ivs_reg_e r;
    r = REG_NONE;
    if (addr[IDX_LSB-1:0] != 2'h0) begin
      r = REG_NONE; // Misaligned words are unmapped
    end else if (addr >= OFF_PRIO_BASE && addr <= OFF_PRIO_LAST) begin
      r = REG_PRIO;
    end else if (addr >= OFF_HANDLER_BASE && addr <= OFF_HANDLER_LAST) begin
      r = REG_HANDLER;
    end else begin
      case (addr)
        OFF_NORMAL_VEC: r = REG_NORMAL_VEC;
        OFF_FAST_VEC: r = REG_FAST_VEC;
        OFF_CUR_SRC: r = REG_CUR_SRC;
        OFF_PENDING: r = REG_PENDING;
        OFF_ENABLED: r = REG_ENABLED;
        OFF_CORE_LINES: r = REG_CORE_LINES;
        OFF_PROTECT: r = REG_PROTECT;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ivs_mem_if mem_if (); // Handler memory carrier
  ivs_phase_e phase_q; // Bus transfer phase
  ivs_reg_e reg_sel; // Register addressed now
  logic [SRC_W-1:0] word_idx; // Word index inside a register bank
  logic setup; // Setup cycle of a transfer
  logic done; // Completing edge of a transfer
  logic [EXT_CNT-1:0] ext_s1_q; // Pin synchroniser, first stage
  logic [EXT_CNT-1:0] ext_s2_q; // Pin synchroniser, second stage
  logic [DATA_W-1:0] pending_q; // Pending view
  logic [DATA_W-1:0] enabled_q; // Enabled view
  logic [NUM_SRC*PRIO_W-1:0] prio_q; // Priority of each source
  logic protect_q; // Protect mode control
  logic sel_valid; // A normal source is eligible
  logic [SRC_W-1:0] sel_idx; // Eligible source number
  logic [PRIO_W-1:0] sel_prio; // Its priority
  logic cap_valid_q; // Eligibility captured at setup
  logic [SRC_W-1:0] cap_idx_q; // Source captured at setup
  logic [SRC_W-1:0] cur_q; // Current source number
  logic in_service_q; // A normal source is being served
  logic commit; // Context takes the captured source
  logic fast_active; // Fast line wanted
  logic normal_active; // Normal line wanted

  assign reg_sel = decode(i_paddr);
  assign word_idx = i_paddr[IDX_LSB +: SRC_W];
  assign setup = i_psel && !i_penable;
  assign done = i_psel && i_penable && o_pready;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  ivs_handler_mem u_mem (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .mem_port(mem_if.mem)
  );

  ivs_prio_select u_select (
    .i_pending(pending_q),
    .i_enabled(enabled_q),
    .i_prio(prio_q),
    .o_valid(sel_valid),
    .o_index(sel_idx),
    .o_prio(sel_prio)
  );

  // Memory read index chosen in the setup cycle, so data stand next cycle
  always_comb begin
    case (reg_sel)
      REG_NORMAL_VEC: mem_if.rd_idx = sel_idx; // R3
      REG_FAST_VEC: mem_if.rd_idx = FAST_SRC; // R5
      default: mem_if.rd_idx = word_idx;
    endcase
  end

  // Handler words are written on the completing edge only
  assign mem_if.wr_en = done && i_pwrite && reg_sel == REG_HANDLER; // R1
  assign mem_if.wr_idx = word_idx;
  assign mem_if.wr_data = i_pwdata;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer phase: one wait cycle lets the registered memory answer
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      phase_q <= PH_IDLE;
    end else begin
      case (phase_q)
        PH_IDLE: if (setup) begin
          phase_q <= PH_WAIT;
        end
        PH_WAIT: phase_q <= PH_DONE;
        PH_DONE: phase_q <= PH_IDLE;
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // Ready is high for exactly the one access cycle after the wait
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= phase_q == PH_WAIT;
    end
  end

  // Read data and error are loaded together with ready
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_prdata <= ZERO_WORD; // R15
      o_pslverr <= 1'b0;
    end else if (phase_q == PH_WAIT) begin
      o_pslverr <= reg_sel == REG_NONE;
      case (reg_sel)
        REG_PRIO: o_prdata <= DATA_W'(prio_q[word_idx*PRIO_W +: PRIO_W]);
        REG_HANDLER: o_prdata <= mem_if.rd_data; // R1
        // No eligible source means nothing to serve: read zero
        REG_NORMAL_VEC: o_prdata <= cap_valid_q ? mem_if.rd_data : ZERO_WORD; // R2 R4
        REG_FAST_VEC: o_prdata <= mem_if.rd_data; // R5
        REG_CUR_SRC: o_prdata <= DATA_W'(cur_q); // R6
        REG_PENDING: o_prdata <= pending_q; // R7
        REG_ENABLED: o_prdata <= enabled_q; // R8
        REG_CORE_LINES: begin
          o_prdata <= ZERO_WORD;
          o_prdata[CORE_FAST_BIT] <= !o_fast_request_line_n; // R9
          o_prdata[CORE_NORMAL_BIT] <= !o_normal_request_line_n; // R10
        end
        REG_PROTECT: o_prdata <= DATA_W'(protect_q);
        default: o_prdata <= ZERO_WORD;
      endcase
    end else begin
      o_pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External request pins pass two flip-flops before use
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
    end else begin
      ext_s1_q <= i_external_request;
      ext_s2_q <= ext_s1_q;
    end
  end

  // Pending view: internal bits from the controller, external from the pins
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pending_q <= ZERO_WORD; // R13
    end else begin
      pending_q <= i_pending & INT_SRC_MASK; // R7
      pending_q[EXT_LSB +: EXT_CNT] <= ext_s2_q; // R13
    end
  end

  // Enabled view; unused bit positions always read zero
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      enabled_q <= ZERO_WORD; // R15
    end else begin
      enabled_q <= i_enabled & SRC_MASK; // R8
    end
  end

  // Priority words and protect control are the only writable state here
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      prio_q <= '0;
      protect_q <= 1'b0;
    end else if (done && i_pwrite) begin // R14
      if (reg_sel == REG_PRIO) begin
        prio_q[word_idx*PRIO_W +: PRIO_W] <= i_pwdata[PRIO_W-1:0]; // R12
      end
      if (reg_sel == REG_PROTECT) begin
        protect_q <= i_pwdata[PROTECT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture the eligible source when the vector read is set up, so the
  // word returned and the source committed are the same one
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cap_valid_q <= 1'b0;
      cap_idx_q <= ZERO_SRC;
    end else if (setup && reg_sel == REG_NORMAL_VEC) begin
      cap_valid_q <= sel_valid; // R3
      cap_idx_q <= sel_idx;
    end
  end

  // Normal mode commits on the read; protect mode only on the write, so
  // a debugger read leaves the context alone
  assign commit = done && reg_sel == REG_NORMAL_VEC && cap_valid_q &&
    (protect_q ? i_pwrite : !i_pwrite); // R11

  // Current context; acknowledge wins over an end of service in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cur_q <= ZERO_SRC; // R15
      in_service_q <= 1'b0;
    end else if (commit) begin
      cur_q <= cap_idx_q; // R6 R11
      in_service_q <= 1'b1;
    end else if (i_end_of_service) begin
      cur_q <= ZERO_SRC;
      in_service_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core request lines, active low; the normal line rises (is released) on acknowledge
  assign fast_active = pending_q[FAST_SRC] && enabled_q[FAST_SRC];
  assign normal_active = sel_valid && !in_service_q && !commit;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_fast_request_line_n <= 1'b1;
      o_normal_request_line_n <= 1'b1;
      o_current_source <= ZERO_SRC;
      o_in_service <= 1'b0;
    end else begin
      o_fast_request_line_n <= !fast_active; // R9
      o_normal_request_line_n <= !normal_active; // R10
      o_current_source <= cur_q;
      o_in_service <= in_service_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence setup_s;
    i_psel && !i_penable && phase_q == PH_IDLE;
  endsequence

  sequence answer_s;
    !o_pready ##1 o_pready;
  endsequence

  // Every transfer answers exactly two cycles after setup
  bus_answer_a: assert property (setup_s |=> answer_s) // R14
    else $error("ready not two cycles after setup");

  // Fast vector read returns word 0
  fast_vector_a: assert property (setup_s and reg_sel == REG_FAST_VEC
    ##1 1'b1 ##1 1'b1 |-> o_prdata == mem_if.fast_word) // R5
    else $error("fast vector word mismatch");

  // Normal vector with no eligible source reads zero
  vector_zero_a: assert property ((setup_s and reg_sel == REG_NORMAL_VEC
    && !sel_valid) |-> ##2 o_prdata == ZERO_WORD) // R4
    else $error("normal vector not zero");

  // Normal mode read commits the captured source
  read_commit_a: assert property (done && !protect_q && !i_pwrite &&
    reg_sel == REG_NORMAL_VEC && cap_valid_q |=> cur_q == $past(cap_idx_q)
    && in_service_q) // R2
    else $error("read did not commit source");

  // Protect mode read leaves context unchanged
  protect_read_a: assert property (done && protect_q && !i_pwrite &&
    !i_end_of_service |=> $stable(cur_q) && $stable(in_service_q)) // R11
    else $error("protect read changed context");

  // Write to status register changes nothing
  status_write_a: assert property (done && i_pwrite && reg_sel == REG_CUR_SRC
    && !i_end_of_service |=> $stable(cur_q)) // R14
    else $error("status write changed source");

  // Selected source is an eligible normal source
  select_valid_a: assert property (sel_valid |-> sel_idx != FAST_SRC &&
    pending_q[sel_idx] && enabled_q[sel_idx]) // R12
    else $error("selected source not eligible");

  // External pending bits follow synchronised pins
  ext_pending_a: assert property (1'b1 |=> pending_q[EXT_LSB +: EXT_CNT] ==
    $past(ext_s2_q)) // R13
    else $error("external pending lost");

  // Fast line follows fast pending and enabled
  fast_line_a: assert property (fast_active |=> !o_fast_request_line_n) // R9
    else $error("fast line not asserted");

  // Normal line is released while a source is served
  normal_line_a: assert property (in_service_q |=> o_normal_request_line_n) // R10
    else $error("normal line active in service");
endmodule

/* File: testbench/ivs_core_model.sv */
// Processor core model: APB master issuing register transfers
module ivs_core_model (
  input wire logic i_clock,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [ivs_pkg::ADDR_W-1:0] o_paddr,
  output logic [ivs_pkg::DATA_W-1:0] o_pwdata,
  input wire logic [ivs_pkg::DATA_W-1:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import ivs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Bus idle at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = '0;
    o_pwdata = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                      input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata,
                      output logic err, output bit hung);
    int n;
    hung = 1'b1;
    rdata = '0;
    err = 1'b0;
    n = 0;
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= addr;
    o_pwdata <= wdata;
    @(posedge i_clock);
    o_penable <= 1'b1;
    // Bounded wait, the slave latency is not assumed
    while (n < 16) begin
      @(posedge i_clock);
      n = n + 1;
      if (i_pready === 1'b1) begin
        rdata = i_prdata;
        err = i_pslverr;
        hung = 1'b0;
        break;
      end
    end
    // Released lines show the inverse so stale values never look valid
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~addr;
    o_pwdata <= ~wdata;
  endtask
endmodule

/* File: testbench/tb_irq_vector_status_readback.sv */
// Self-checking bench for the vector readback block
module tb_irq_vector_status_readback;
  timeunit 1ns;
  timeprecision 1ps;
  import ivs_pkg::*;

  localparam logic [DATA_W-1:0] HBASE = 32'hC0DE0000; // Handler word pattern
  logic clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic eos, fast_n, normal_n, in_service;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, pending, enabled;
  logic [EXT_CNT-1:0] ext_req;
  logic [SRC_W-1:0] cur_src;
  int miscompares, samples_checked;
  int idx[7] = '{0, 1, 3, 5, 7, 18, 31}; // Handler words exercised

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  ivs_vector_regs DUT (.i_clock(clock), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pending(pending), .i_enabled(enabled),
    .i_external_request(ext_req), .i_end_of_service(eos),
    .o_fast_request_line_n(fast_n), .o_normal_request_line_n(normal_n),
    .o_current_source(cur_src), .o_in_service(in_service));

  ivs_core_model u_core (.i_clock(clock), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic wrap_up();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // Bus transfer with response check; a hang ends the run
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [DATA_W-1:0] exp, input logic exp_err);
    logic [DATA_W-1:0] r;
    logic e;
    bit hung;
    u_core.xfer(wr, a, d, r, e, hung);
    if (hung) begin
      $display("[ERR] pready expected 1 seen 0");
      miscompares++;
      wrap_up();
    end else begin
      if (!wr) chk($sformatf("read %h", a), exp, r);
      chk("pslverr", 32'(exp_err), 32'(e));
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    bus(1'b0, a, '0, exp, 1'b0);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d, '0, 1'b0);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One-cycle end of service pulse
  task automatic end_service();
    @(posedge clock);
    eos <= 1'b1;
    @(posedge clock);
    eos <= 1'b0;
    ticks(3);
  endtask

  // Check the core lines and current context outputs
  task automatic lines(input logic f, input logic n, input int src, input logic svc);
    chk("fast line", 32'(f), 32'(fast_n));
    chk("normal line", 32'(n), 32'(normal_n));
    chk("current source", 32'(src), 32'(cur_src));
    chk("in service", 32'(svc), 32'(in_service));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset values, pins seen at reset, read-only registers ignore writes
  task automatic test_reset();
    logic [ADDR_W-1:0] a;
    lines(1'b1, 1'b1, 0, 1'b0);
    rd(OFF_HANDLER_BASE, '0);
    rd(OFF_HANDLER_LAST, '0);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        a = OFF_NORMAL_VEC + ADDR_W'(4 * i);
        rd(a, (a == OFF_PENDING) ? 32'h00020000 : '0);
        if (p == 0) wr(a, 32'hFFFFFFFF);
      end
    end
    $display("reset test finished");
  endtask

  // Handler words read back what was written; bad addresses refused
  task automatic test_handlers();
    foreach (idx[k]) wr(OFF_HANDLER_BASE + ADDR_W'(4 * idx[k]), HBASE + 32'(idx[k]));
    foreach (idx[k]) rd(OFF_HANDLER_BASE + ADDR_W'(4 * idx[k]), HBASE + 32'(idx[k]));
    bus(1'b0, 12'h118, '0, '0, 1'b1);
    bus(1'b1, 12'h086, 32'h12345678, '0, 1'b1);
    rd(12'h084, HBASE + 32'h1);
    $display("handler test finished");
  endtask

  // Fast vector and fast line
  task automatic test_fast();
    rd(OFF_FAST_VEC, HBASE);
    pending <= 32'h1;
    enabled <= 32'h1;
    ticks(4);
    lines(1'b0, 1'b1, 0, 1'b0);
    rd(OFF_CORE_LINES, 32'h1);
    pending <= '0;
    enabled <= '0;
    ticks(4);
    lines(1'b1, 1'b1, 0, 1'b0);
    rd(OFF_CORE_LINES, '0);
    $display("fast test finished");
  endtask

  // Highest priority wins, tie goes to lower number, read commits
  task automatic test_normal();
    wr(OFF_PRIO_BASE + 12'h00C, 32'h2);
    wr(OFF_PRIO_BASE + 12'h014, 32'h5);
    wr(OFF_PRIO_BASE + 12'h01C, 32'h5);
    pending <= 32'h000000A8;
    enabled <= 32'h000000A8;
    ticks(4);
    lines(1'b1, 1'b0, 0, 1'b0);
    rd(OFF_CORE_LINES, 32'h2);
    rd(OFF_NORMAL_VEC, HBASE + 32'h5);
    ticks(2);
    lines(1'b1, 1'b1, 5, 1'b1);
    rd(OFF_CUR_SRC, 32'h5);
    rd(OFF_CORE_LINES, '0);
    pending <= '0;
    end_service();
    lines(1'b1, 1'b1, 0, 1'b0);
    rd(OFF_NORMAL_VEC, '0);
    rd(OFF_CUR_SRC, '0);
    $display("normal test finished");
  endtask

  // Protect mode: read leaves context, vector write commits
  task automatic test_protect();
    wr(OFF_PROTECT, 32'h1);
    wr(OFF_PRIO_BASE + 12'h048, 32'h7);
    ext_req <= 3'b100;
    pending <= 32'h00000080;
    enabled <= 32'h00040080;
    ticks(5);
    rd(OFF_PENDING, 32'h00040080);
    rd(OFF_NORMAL_VEC, HBASE + 32'h12);
    ticks(2);
    lines(1'b1, 1'b0, 0, 1'b0);
    rd(OFF_CUR_SRC, '0);
    wr(OFF_NORMAL_VEC, 32'h0);
    ticks(2);
    lines(1'b1, 1'b1, 18, 1'b1);
    rd(OFF_CUR_SRC, 32'h12);
    ext_req <= '0;
    pending <= '0;
    enabled <= '0;
    end_service();
    wr(OFF_PROTECT, '0);
    $display("protect test finished");
  endtask

  // Pending and enabled bit positions
  task automatic test_masks();
    pending <= 32'hFFFFFFFF;
    enabled <= 32'hFFFFFFFF;
    ext_req <= 3'b011;
    ticks(5);
    rd(OFF_PENDING, 32'h000301FF);
    rd(OFF_ENABLED, SRC_MASK);
    pending <= '0;
    enabled <= '0;
    ext_req <= '0;
    ticks(5);
    rd(OFF_PENDING, '0);
    $display("mask test finished");
  endtask

  // Reset in mid-run clears handler words written earlier
  task automatic test_reset_again();
    nrst <= 1'b0;
    ticks(2);
    nrst <= 1'b1;
    ticks(4);
    lines(1'b1, 1'b1, 0, 1'b0);
    rd(OFF_HANDLER_BASE + 12'h004, '0);
    rd(OFF_FAST_VEC, '0);
    $display("second reset test finished");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    miscompares = 0;
    samples_checked = 0;
    nrst = 1'b0;
    pending = '0;
    enabled = '0;
    ext_req = 3'b010;
    eos = 1'b0;
    ticks(8);
    nrst <= 1'b1;
    ticks(4);
    test_reset();
    test_handlers();
    test_fast();
    test_normal();
    test_protect();
    test_masks();
    test_reset_again();
    wrap_up();
  end
endmodule
